// *** include/e1ofi_pkg.sv ***
// constants for the e1 transmit frame overhead insertion block
package e1ofi_pkg;
  // ------------------------------------------------------------
  // channels and register indexes (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam int unsigned NUM_CHAN = 8;
  localparam logic [7:0] IDX_MODE = 8'h62;
  localparam logic [7:0] IDX_SA_CTRL = 8'h64;
  localparam logic [7:0] IDX_SA6_CW = 8'h67;
  localparam logic [7:0] IDX_SA7_CW = 8'h68;
  localparam logic [7:0] IDX_SA8_CW = 8'h69;
  localparam logic [7:0] IDX_EXTRA = 8'h6A;
  localparam logic [7:0] IDX_MAINT_A = 8'h6B;
  localparam logic [7:0] IDX_MAINT_B = 8'h6C;
  localparam logic [7:0] IDX_IRQ_EN = 8'h6D;
  localparam logic [7:0] IDX_IRQ_FLAG = 8'h6E;
  localparam logic [11:0] IDX_CHAN_STRIDE = 12'h100;
  // ------------------------------------------------------------
  // reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h06;
  localparam logic [7:0] RST_SA_CTRL = 8'h00;
  localparam logic [7:0] RST_CW = 8'h0F;
  localparam logic [7:0] RST_EXTRA = 8'h0B;
  localparam logic [7:0] RST_MAINT = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] MASK_MODE = 8'h4F;
  localparam logic [7:0] MASK_SA_CTRL = 8'h07;
  localparam logic [7:0] MASK_CW = 8'h0F;
  localparam logic [7:0] MASK_EXTRA = 8'h0B;
  localparam logic [7:0] MASK_MAINT_A = 8'h3F;
  localparam logic [7:0] MASK_MAINT_B = 8'h07;
  localparam logic [7:0] MASK_IRQ = 8'h1F;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned MODE_FRAME_GEN_OFF = 0;
  localparam int unsigned MODE_CRC_MULTI_GEN_EN = 1;
  localparam int unsigned MODE_CAS_MULTI_GEN_EN = 2;
  localparam int unsigned MODE_MODIFIED_CRC = 3;
  localparam int unsigned MODE_EXTRA_BITS_REPLACE_OFF = 6;
  localparam int unsigned SA_SIX_INSERT_EN = 2;
  localparam int unsigned SA_SEVEN_INSERT_EN = 1;
  localparam int unsigned SA_EIGHT_INSERT_EN = 0;
  localparam int unsigned EXTRA_X0 = 3;
  localparam int unsigned EXTRA_X1 = 1;
  localparam int unsigned EXTRA_X2 = 0;
  localparam int unsigned MA_SLOT16_ZERO_FILL = 5;
  localparam int unsigned MA_SLOT16_ONES_FILL = 4;
  localparam int unsigned MA_Y_BIT_VALUE = 3;
  localparam int unsigned MA_ALARM_CRITERIA_SELECT = 2;
  localparam int unsigned MA_AUTO_REMOTE_ALARM_EN = 1;
  localparam int unsigned MA_MANUAL_REMOTE_ALARM = 0;
  localparam int unsigned MB_ALIGN_SHIFT_TOGGLE = 2;
  localparam int unsigned MB_TX_ZERO_FILL = 1;
  localparam int unsigned MB_TX_ONES_FILL = 0;
  localparam int unsigned FLAG_SUBMF = 4;
  localparam int unsigned FLAG_ALIGN_WORD = 3;
  localparam int unsigned FLAG_SIG_MULTI = 2;
  localparam int unsigned FLAG_CRC_MULTI = 1;
  localparam int unsigned FLAG_BASIC_FRAME = 0;
  // ------------------------------------------------------------
  // frame geometry (bit position 0 is bit 1 of a slot)
  // ------------------------------------------------------------
  localparam logic [4:0] SLOT_ALIGN = 5'h00;
  localparam logic [4:0] SLOT_SIGNAL = 5'h10;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam logic [2:0] BITPOS_A = 3'h2;
  localparam logic [2:0] BITPOS_SA6 = 3'h5;
  localparam logic [2:0] BITPOS_SA7 = 3'h6;
  localparam logic [2:0] BITPOS_SA8 = 3'h7;
  localparam logic [2:0] BITPOS_X0 = 3'h4;
  localparam logic [2:0] BITPOS_Y = 3'h5;
  localparam logic [2:0] BITPOS_X1 = 3'h6;
  localparam logic [2:0] BITPOS_X2 = 3'h7;
endpackage : e1ofi_pkg

// *** verilog/e1ofi_pos.sv ***
// frame position counter with one-bit deletion for alignment shifts
`timescale 1ns/1ps
`default_nettype none
module e1ofi_pos (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic bit_en_in,
  input wire logic shift_req_in,
  output logic accept_out,
  output logic [2:0] bitpos_out,
  output logic [4:0] slot_out,
  output logic [3:0] frame_out
);
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  logic shift_pend_q;
  logic [2:0] bitpos_q;
  logic [4:0] slot_q;
  logic [3:0] frame_q;
  logic take_shift;

  // a pending shift swallows the next incoming bit
  assign take_shift = bit_en_in && (shift_pend_q || shift_req_in);
  assign accept_out = bit_en_in && !take_shift;
  assign bitpos_out = bitpos_q;
  assign slot_out = slot_q;
  assign frame_out = frame_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shift_pend_q <= 1'b0;
    end else if (ce_in) begin
      // a request that lands with no bit waits for the next one
      shift_pend_q <= (shift_pend_q || shift_req_in) && !bit_en_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bitpos_q <= 3'h0;
      slot_q <= 5'h00;
      frame_q <= 4'h0;
    end else if (ce_in && accept_out) begin
      bitpos_q <= bitpos_q + 3'h1;
      if (bitpos_q == e1ofi_pkg::BIT_LAST) begin
        slot_q <= slot_q + 5'h01;
        if (slot_q == e1ofi_pkg::SLOT_LAST) begin
          frame_q <= frame_q + 4'h1;
        end
      end
    end
  end
endmodule : e1ofi_pos
`default_nettype wire

// *** verilog/e1ofi_top.sv ***
// eight-channel e1 transmit frame overhead insertion with apb registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// - basic frames insert first spare codeword bit
// - crc multiframe inserts four codeword bits per submultiframe
// - signaling multiframe carries programmed extra bits
// - slot sixteen zero fill while set
// - slot sixteen ones fill while set
// - y bit sent in signaling frame zero
// - alarm criteria select picks alarm conditions
// - automatic alarm sets a bit when enabled
// - manual alarm sets a bit whenever frame generation is on
// - each shift toggle change deletes one bit
// - whole stream zero fill while set
// - whole stream ones fill while set
// - flags reach interrupt only when enabled
// - flag at each submultiframe start
// - flag at each alignment word start
// - flag at each signaling multiframe start
// - flag at each crc multiframe start
// - flag at each basic frame start
// - writing one clears flag, zero keeps
// - eight register copies spaced by 0x100
// - frame generation and multiframe type enables
// - spare groups replaced only when enabled
// - extra bit replacement off when disabled
module e1ofi_top #(
  parameter int unsigned NCH = e1ofi_pkg::NUM_CHAN
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [NCH-1:0] TX_BIT_EN_IN,
  input wire logic [NCH-1:0] TX_DATA_IN,
  input wire logic [NCH-1:0] RX_FRAME_LOSS_IN,
  input wire logic [NCH-1:0] RX_INTERWORK_IN,
  input wire logic [NCH-1:0] RX_OFFLINE_LOSS_IN,
  output logic [NCH-1:0] TX_VALID_OUT,
  output logic [NCH-1:0] TX_DATA_OUT,
  output logic IRQ_OUT
);
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [13:0] word_idx;
  logic [2:0] chan_sel;
  logic [7:0] reg_sel;
  logic reg_known;
  logic addr_ok;
  logic setup_ph;
  logic wr_acc;
  logic [7:0] wdata8;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [7:0] rd_byte;

  assign word_idx = PADDR_IN[15:2];
  assign chan_sel = word_idx[10:8];
  assign reg_sel = word_idx[7:0];
  assign wdata8 = PWDATA_IN[7:0];
  assign setup_ph = PSEL_IN && !PENABLE_IN;

  always_comb begin
    case (reg_sel)
      e1ofi_pkg::IDX_MODE,
      e1ofi_pkg::IDX_SA_CTRL,
      e1ofi_pkg::IDX_SA6_CW,
      e1ofi_pkg::IDX_SA7_CW,
      e1ofi_pkg::IDX_SA8_CW,
      e1ofi_pkg::IDX_EXTRA,
      e1ofi_pkg::IDX_MAINT_A,
      e1ofi_pkg::IDX_MAINT_B,
      e1ofi_pkg::IDX_IRQ_EN,
      e1ofi_pkg::IDX_IRQ_FLAG: reg_known = 1'b1;
      default: reg_known = 1'b0;
    endcase
  end

  // channel copies repeat every stride; higher index bits must be zero
  assign addr_ok = reg_known && (word_idx[13:11] == 3'h0) && (PADDR_IN[1:0] == 2'h0)
    && (32'(chan_sel) < NCH);
  assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && addr_ok && CE_IN;

  // ------------------------------------------------------------
  // per-channel register storage
  // ------------------------------------------------------------
  logic [7:0] mode_q [NCH];
  logic [7:0] sa_ctrl_q [NCH];
  logic [7:0] cw6_q [NCH];
  logic [7:0] cw7_q [NCH];
  logic [7:0] cw8_q [NCH];
  logic [7:0] extra_q [NCH];
  logic [7:0] maint_a_q [NCH];
  logic [7:0] maint_b_q [NCH];
  logic [7:0] irq_en_q [NCH];
  logic [7:0] irq_flag_q [NCH];
  logic [NCH-1:0] chan_irq;

  // ------------------------------------------------------------
  // read data, captured in the setup phase
  // ------------------------------------------------------------
  always_comb begin
    case (reg_sel)
      e1ofi_pkg::IDX_MODE: rd_byte = mode_q[chan_sel];
      e1ofi_pkg::IDX_SA_CTRL: rd_byte = sa_ctrl_q[chan_sel];
      e1ofi_pkg::IDX_SA6_CW: rd_byte = cw6_q[chan_sel];
      e1ofi_pkg::IDX_SA7_CW: rd_byte = cw7_q[chan_sel];
      e1ofi_pkg::IDX_SA8_CW: rd_byte = cw8_q[chan_sel];
      e1ofi_pkg::IDX_EXTRA: rd_byte = extra_q[chan_sel];
      e1ofi_pkg::IDX_MAINT_A: rd_byte = maint_a_q[chan_sel];
      e1ofi_pkg::IDX_MAINT_B: rd_byte = maint_b_q[chan_sel];
      e1ofi_pkg::IDX_IRQ_EN: rd_byte = irq_en_q[chan_sel];
      e1ofi_pkg::IDX_IRQ_FLAG: rd_byte = irq_flag_q[chan_sel];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (CE_IN && setup_ph) begin
      prdata_q <= (addr_ok && !PWRITE_IN) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      slverr_q <= !addr_ok;
    end
  end

  // zero wait states; a frozen clock enable stretches the access
  assign PREADY_OUT = CE_IN;
  assign PRDATA_OUT = prdata_q;
  assign PSLVERR_OUT = slverr_q && PSEL_IN && PENABLE_IN;
  assign IRQ_OUT = |chan_irq;

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic wr_me;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic shift_prev_q;
    logic shift_req;
    logic accept;
    logic [2:0] bitpos;
    logic [4:0] slot;
    logic [3:0] frame;
    logic gen_on;
    logic crc_on;
    logic cas_on;
    logic alarm;
    logic [1:0] cw_idx;
    logic [1:0] cw_sel;
    logic bit_d;
    logic valid_q;
    logic data_q;
    logic first_bit;
    logic odd_ts0;
    logic cas_slot;

    assign wr_me = wr_acc && (32'(chan_sel) == c);

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        mode_q[c] <= e1ofi_pkg::RST_MODE;
        sa_ctrl_q[c] <= e1ofi_pkg::RST_SA_CTRL;
        cw6_q[c] <= e1ofi_pkg::RST_CW;
        cw7_q[c] <= e1ofi_pkg::RST_CW;
        cw8_q[c] <= e1ofi_pkg::RST_CW;
        extra_q[c] <= e1ofi_pkg::RST_EXTRA;
        maint_a_q[c] <= e1ofi_pkg::RST_MAINT;
        maint_b_q[c] <= e1ofi_pkg::RST_MAINT;
        irq_en_q[c] <= e1ofi_pkg::RST_IRQ;
      end else if (wr_me) begin
        case (reg_sel)
          e1ofi_pkg::IDX_MODE: mode_q[c] <= wdata8 & e1ofi_pkg::MASK_MODE;
          e1ofi_pkg::IDX_SA_CTRL: sa_ctrl_q[c] <= wdata8 & e1ofi_pkg::MASK_SA_CTRL;
          e1ofi_pkg::IDX_SA6_CW: cw6_q[c] <= wdata8 & e1ofi_pkg::MASK_CW;
          e1ofi_pkg::IDX_SA7_CW: cw7_q[c] <= wdata8 & e1ofi_pkg::MASK_CW;
          e1ofi_pkg::IDX_SA8_CW: cw8_q[c] <= wdata8 & e1ofi_pkg::MASK_CW;
          e1ofi_pkg::IDX_EXTRA: extra_q[c] <= wdata8 & e1ofi_pkg::MASK_EXTRA;
          e1ofi_pkg::IDX_MAINT_A: maint_a_q[c] <= wdata8 & e1ofi_pkg::MASK_MAINT_A;
          e1ofi_pkg::IDX_MAINT_B: maint_b_q[c] <= wdata8 & e1ofi_pkg::MASK_MAINT_B;
          e1ofi_pkg::IDX_IRQ_EN: irq_en_q[c] <= wdata8 & e1ofi_pkg::MASK_IRQ;
          default: mode_q[c] <= mode_q[c];
        endcase
      end
    end

    // ----------------------------------------------------------
    // frame position and alignment shift
    // ----------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        shift_prev_q <= 1'b0;
      end else if (CE_IN) begin
        shift_prev_q <= maint_b_q[c][e1ofi_pkg::MB_ALIGN_SHIFT_TOGGLE];
      end
    end

    // either edge of the toggle asks for one deleted bit
    assign shift_req = shift_prev_q != maint_b_q[c][e1ofi_pkg::MB_ALIGN_SHIFT_TOGGLE];

    e1ofi_pos u_pos (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .ce_in(CE_IN),
      .bit_en_in(TX_BIT_EN_IN[c]),
      .shift_req_in(shift_req),
      .accept_out(accept),
      .bitpos_out(bitpos),
      .slot_out(slot),
      .frame_out(frame)
    );

    assign gen_on = !mode_q[c][e1ofi_pkg::MODE_FRAME_GEN_OFF];
    assign crc_on = gen_on && mode_q[c][e1ofi_pkg::MODE_CRC_MULTI_GEN_EN];
    assign cas_on = gen_on && mode_q[c][e1ofi_pkg::MODE_CAS_MULTI_GEN_EN];
    assign first_bit = accept && (bitpos == 3'h0) && (slot == e1ofi_pkg::SLOT_ALIGN);
    assign odd_ts0 = (slot == e1ofi_pkg::SLOT_ALIGN) && frame[0];
    assign cas_slot = cas_on && (slot == e1ofi_pkg::SLOT_SIGNAL) && (frame == 4'h0);

    // ----------------------------------------------------------
    // remote alarm criteria
    // ----------------------------------------------------------
    always_comb begin
      alarm = maint_a_q[c][e1ofi_pkg::MA_MANUAL_REMOTE_ALARM];
      if (maint_a_q[c][e1ofi_pkg::MA_AUTO_REMOTE_ALARM_EN]) begin
        if (maint_a_q[c][e1ofi_pkg::MA_ALARM_CRITERIA_SELECT]) begin
          alarm = alarm || RX_FRAME_LOSS_IN[c];
        end else begin
          alarm = alarm || RX_FRAME_LOSS_IN[c] || RX_INTERWORK_IN[c] || RX_OFFLINE_LOSS_IN[c];
        end
      end
    end

    // sa bit n of a submultiframe sits in odd frame 2n-1; bit 1 is field bit 3
    assign cw_idx = crc_on ? frame[2:1] : 2'h0;
    assign cw_sel = 2'h3 - cw_idx;

    // ----------------------------------------------------------
    // overhead insertion and fills, later stages win
    // ----------------------------------------------------------
    always_comb begin
      bit_d = TX_DATA_IN[c];
      if (gen_on && odd_ts0) begin
        if (bitpos == e1ofi_pkg::BITPOS_A && alarm) begin
          bit_d = 1'b1;
        end
        if (bitpos == e1ofi_pkg::BITPOS_SA6 && sa_ctrl_q[c][e1ofi_pkg::SA_SIX_INSERT_EN]) begin
          bit_d = cw6_q[c][cw_sel];
        end
        if (bitpos == e1ofi_pkg::BITPOS_SA7 && sa_ctrl_q[c][e1ofi_pkg::SA_SEVEN_INSERT_EN]) begin
          bit_d = cw7_q[c][cw_sel];
        end
        if (bitpos == e1ofi_pkg::BITPOS_SA8 && sa_ctrl_q[c][e1ofi_pkg::SA_EIGHT_INSERT_EN]) begin
          bit_d = cw8_q[c][cw_sel];
        end
      end
      if (cas_slot) begin
        if (bitpos == e1ofi_pkg::BITPOS_Y) begin
          bit_d = maint_a_q[c][e1ofi_pkg::MA_Y_BIT_VALUE];
        end
        if (!mode_q[c][e1ofi_pkg::MODE_EXTRA_BITS_REPLACE_OFF]) begin
          if (bitpos == e1ofi_pkg::BITPOS_X0) begin
            bit_d = extra_q[c][e1ofi_pkg::EXTRA_X0];
          end
          if (bitpos == e1ofi_pkg::BITPOS_X1) begin
            bit_d = extra_q[c][e1ofi_pkg::EXTRA_X1];
          end
          if (bitpos == e1ofi_pkg::BITPOS_X2) begin
            bit_d = extra_q[c][e1ofi_pkg::EXTRA_X2];
          end
        end
      end
      if (slot == e1ofi_pkg::SLOT_SIGNAL) begin
        if (maint_a_q[c][e1ofi_pkg::MA_SLOT16_ZERO_FILL]) begin
          bit_d = 1'b0;
        end
        // ones wins when both fills are set
        if (maint_a_q[c][e1ofi_pkg::MA_SLOT16_ONES_FILL]) begin
          bit_d = 1'b1;
        end
      end
      if (maint_b_q[c][e1ofi_pkg::MB_TX_ZERO_FILL]) begin
        bit_d = 1'b0;
      end
      // whole stream ones fill outranks the zero fill
      if (maint_b_q[c][e1ofi_pkg::MB_TX_ONES_FILL]) begin
        bit_d = 1'b1;
      end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        valid_q <= 1'b0;
        data_q <= 1'b0;
      end else if (CE_IN) begin
        valid_q <= accept;
        if (accept) begin
          data_q <= bit_d;
        end
      end
    end

    assign TX_VALID_OUT[c] = valid_q;
    assign TX_DATA_OUT[c] = data_q;

    // ----------------------------------------------------------
    // boundary flags
    // ----------------------------------------------------------
    always_comb begin
      flag_set = 8'h00;
      flag_set[e1ofi_pkg::FLAG_BASIC_FRAME] = gen_on && first_bit;
      flag_set[e1ofi_pkg::FLAG_ALIGN_WORD] = gen_on && first_bit && !frame[0];
      flag_set[e1ofi_pkg::FLAG_SUBMF] = crc_on && first_bit && (frame[2:0] == 3'h0);
      flag_set[e1ofi_pkg::FLAG_CRC_MULTI] = crc_on && first_bit && (frame == 4'h0);
      flag_set[e1ofi_pkg::FLAG_SIG_MULTI] = cas_on && first_bit && (frame == 4'h0);
    end

    assign flag_clr = (wr_me && reg_sel == e1ofi_pkg::IDX_IRQ_FLAG) ? (wdata8 & e1ofi_pkg::MASK_IRQ) : 8'h00;

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
        irq_flag_q[c] <= e1ofi_pkg::RST_IRQ;
      end else if (CE_IN) begin
        // a new event beats a clear in the same cycle
        irq_flag_q[c] <= (irq_flag_q[c] & ~flag_clr) | flag_set;
      end
    end

    assign chan_irq[c] = |(irq_flag_q[c] & irq_en_q[c]);
  end
endmodule : e1ofi_top
`default_nettype wire

// *** verification/e1ofi_chk_sva.sv ***
// assertion checker for the e1 overhead top, channel 0 view
`timescale 1ns/1ps
`default_nettype none
module e1ofi_chk #(
  parameter int unsigned NCH = 8
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [15:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  input wire logic [NCH-1:0] TX_BIT_EN_IN,
  input wire logic [NCH-1:0] TX_VALID_OUT,
  input wire logic [NCH-1:0] TX_DATA_OUT,
  input wire logic IRQ_OUT
);
  logic wr, stb, vld, s16, pend_q, fo_q;
  logic [5:0] ma_q;
  logic [2:0] mb_q;
  logic [39:0] en_q;
  logic [8:0] pos_q;
  assign wr = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT & (PADDR_IN[1:0] == 2'h0) & (PADDR_IN[15:13] == 3'h0);
  assign stb = TX_BIT_EN_IN[0] & CE_IN;
  assign vld = TX_VALID_OUT[0];
  assign s16 = vld & (pos_q[7:3] == 5'h10);
  // mirrors of channel 0 plus the irq enables of all eight channels; a strobe on the write edge itself is not modelled
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pend_q <= 1'b0;
      ma_q <= 6'h00;
      mb_q <= 3'h0;
      en_q <= 40'h0;
      pos_q <= 9'h000;
      fo_q <= 1'b0;
    end else begin
      if (wr && PADDR_IN[12:2] == 11'h06C && PWDATA_IN[2] != mb_q[2]) pend_q <= 1'b1;
      else if (stb) pend_q <= 1'b0;
      if (wr && PADDR_IN[12:2] == 11'h06B) ma_q <= PWDATA_IN[5:0];
      // generation off suppresses the alarm bit
      if (wr && PADDR_IN[12:2] == 11'h062) fo_q <= PWDATA_IN[0];
      if (wr && PADDR_IN[12:2] == 11'h06C) mb_q <= PWDATA_IN[2:0];
      if (wr && PADDR_IN[9:2] == 8'h6D) en_q[PADDR_IN[12:10] * 5 +: 5] <= PWDATA_IN[4:0];
      if (vld) pos_q <= pos_q + 9'h001;
    end
  end
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  bit_origin_a: assert property (vld |-> $past(stb))
    else $error("valid without strobe");
  shift_drop_a: assert property (stb && pend_q |=> !vld)
    else $error("shift kept a bit");
  bit_kept_a: assert property (stb && !pend_q |=> vld)
    else $error("bit lost");
  zero_fill_a: assert property (vld && $past(mb_q[1:0]) == 2'h2 |-> !TX_DATA_OUT[0])
    else $error("zero fill");
  ones_fill_a: assert property (vld && $past(mb_q[0]) |-> TX_DATA_OUT[0])
    else $error("ones fill");
  slot_zero_a: assert property (s16 && $past(ma_q[5:4]) == 2'h2 && !$past(mb_q[0]) |-> !TX_DATA_OUT[0])
    else $error("slot16 zero fill");
  slot_ones_a: assert property (s16 && $past(ma_q[4]) && $past(mb_q[1:0]) != 2'h2 |-> TX_DATA_OUT[0])
    else $error("slot16 ones fill");
  manual_alarm_a: assert property (vld && pos_q == 9'h102 && $past(ma_q[0]) && !$past(fo_q)
    && $past(mb_q[1:0]) == 2'h0 |-> TX_DATA_OUT[0])
    else $error("manual alarm");
  irq_masked_a: assert property (en_q == 40'h0 |-> !IRQ_OUT)
    else $error("masked interrupt");
endmodule : e1ofi_chk
bind e1ofi_top e1ofi_chk #(.NCH(NCH)) e1ofi_chk_inst (
  .CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .CE_IN(CE_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
  .TX_BIT_EN_IN(TX_BIT_EN_IN), .TX_VALID_OUT(TX_VALID_OUT), .TX_DATA_OUT(TX_DATA_OUT), .IRQ_OUT(IRQ_OUT)
);
`default_nettype wire

// *** verification/e1ofi_far_end.sv ***
// far-end line receiver model: keeps one multiframe of received bits
`timescale 1ns/1ps
`default_nettype none
module e1ofi_far_end (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic valid_in,
  input wire logic data_in,
  output logic [11:0] count_out,
  output logic [4095:0] bits_out
);
  // a deleted bit never shows, so the index follows the line itself
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_out <= 12'h000;
      bits_out <= '0;
    end else if (valid_in) begin
      count_out <= count_out + 12'h001;
      bits_out[count_out] <= data_in;
    end
  end
endmodule : e1ofi_far_end
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the e1 overhead insertion top
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rstn, ce, psel, pen, pwr, pready, pslverr, irq, serr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ben, din, rloss, rint, roff, vld, dout;
  logic [11:0] cnt, c0, p;
  logic [4095:0] fb;
  int err_count, checks_done;
  logic [7:0] ix [10] = '{8'h62, 8'h64, 8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E};
  logic [7:0] rv [10] = '{8'h06, 8'h00, 8'h0F, 8'h0F, 8'h0F, 8'h0B, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] mk [10] = '{8'h4F, 8'h07, 8'h0F, 8'h0F, 8'h0F, 8'h0B, 8'h3F, 8'h07, 8'h1F, 8'h00};
  logic [7:0] fv [4] = '{8'h01, 8'h09, 8'h19, 8'h1F};
  int sn [4] = '{256, 256, 1536, 2048};
  logic [3:0] cw [3] = '{4'hA, 4'hC, 4'h5};
  logic [7:0] at [7] = '{8'h25, 8'h23, 8'h29, 8'h64, 8'h69, 8'h08, 8'h11};
  logic [15:0] fl [5] = '{16'h2005, 16'h1002, 16'h0024, 16'h0013, 16'h0007};
  e1ofi_top #(.NCH(8)) e1ofi_top_inst (
    .CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .TX_BIT_EN_IN(ben), .TX_DATA_IN(din), .RX_FRAME_LOSS_IN(rloss), .RX_INTERWORK_IN(rint),
    .RX_OFFLINE_LOSS_IN(roff), .TX_VALID_OUT(vld), .TX_DATA_OUT(dout), .IRQ_OUT(irq));
  e1ofi_far_end e1ofi_far_end_inst (.clk_in(clk), .rstn_in(rstn), .valid_in(vld[0]), .data_in(dout[0]),
    .count_out(cnt), .bits_out(fb));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] addr(input logic [2:0] c, input logic [7:0] i);
    return {3'h0, c, i, 2'h0};
  endfunction : addr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    if (pready !== 1'b1) err_count++;
    if (pready !== 1'b1) close_out();
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [2:0] c, input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, addr(c, i), 32'h0);
    chk("register", {24'h0, e}, rd);
  endtask : rchk
  task automatic send(input int n, input logic d);
    repeat (n) begin
      ben[0] <= 1'b1;
      din[0] <= d;
      @(posedge clk);
      ben[0] <= 1'b0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
  endtask : send
  task automatic rst();
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : rst
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    {psel, pen, pwr, paddr, pwdata} = '0;
    {ben, din, rloss, rint, roff} = '0;
    err_count = 0;
    checks_done = 0;
    rst();
    for (int k = 0; k < 10; k++) begin
      rchk(3'h0, ix[k], rv[k]);
      apb(1'b1, addr(3'h7, ix[k]), 32'hFF);
      rchk(3'h7, ix[k], mk[k]);
      rchk(3'h0, ix[k], rv[k]);
    end
    apb(1'b0, addr(3'h0, 8'h70), 32'h0);
    chk("unmapped error", 32'h1, {31'h0, serr});
    rst();
    send(1, 1'b0);
    rchk(3'h0, 8'h6E, 8'h1F);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, addr(3'h0, 8'h6E), 32'h05);
    rchk(3'h0, 8'h6E, 8'h1A);
    apb(1'b1, addr(3'h0, 8'h6D), 32'h02);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, addr(3'h0, 8'h6E), 32'h1A);
    chk("irq", 32'h0, {31'h0, irq});
    for (int k = 0; k < 4; k++) begin
      send(sn[k], 1'b0);
      rchk(3'h0, 8'h6E, fv[k]);
      apb(1'b1, addr(3'h0, 8'h6E), 32'h1F);
    end
    rst();
    for (int k = 0; k < 6; k++)
      apb(1'b1, addr(3'h0, ix[k + 1]), k == 0 ? 32'h07 : k < 4 ? 32'(cw[k - 1]) : 32'h0A - (k - 4) * 2);
    send(4096, 1'b0);
    for (int f = 1; f < 16; f += 2) begin
      for (int g = 0; g < 3; g++)
        chk("spare", {31'h0, cw[g][3 - ((f >> 1) & 3)]}, {31'h0, fb[f * 256 + 5 + g]});
    end
    chk("extra", 32'h7, {28'h0, fb[135:132]});
    apb(1'b1, addr(3'h0, 8'h62), 32'h46);
    send(4096, 1'b0);
    chk("extra", 32'h2, {28'h0, fb[135:132]});
    apb(1'b1, addr(3'h0, 8'h62), 32'h00);
    apb(1'b1, addr(3'h0, 8'h64), 32'h04);
    send(4096, 1'b0);
    chk("basic spare", 32'h1, {29'h0, fb[775:773]});
    rst();
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, addr(3'h0, 8'h6B), {28'h0, at[k][7:4]});
      {rloss[0], rint[0], roff[0]} <= at[k][3:1];
      p = cnt + 12'h102;
      send(512, 1'b0);
      chk("alarm", {31'h0, at[k][0]}, {31'h0, fb[p]});
    end
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, addr(3'h0, 8'h6B), {24'h0, fl[k][15:8]});
      apb(1'b1, addr(3'h0, 8'h6C), {28'h0, fl[k][7:4]});
      p = cnt + 12'h180;
      send(512, fl[k][2]);
      chk("slot16", {31'h0, fl[k][1]}, {31'h0, fb[p]});
      p = p - 12'h058;
      chk("stream", {31'h0, fl[k][0]}, {31'h0, fb[p]});
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, addr(3'h0, 8'h6C), 32'(4 - 4 * k));
      c0 = cnt;
      send(8, 1'b0);
      chk("shift count", {20'h0, c0 + 12'h007}, {20'h0, cnt});
    end
    // strobes while the clock enable is low must not reach the line
    ce <= 1'b0;
    c0 = cnt;
    send(4, 1'b1);
    ce <= 1'b1;
    chk("frozen count", {20'h0, c0}, {20'h0, cnt});
    close_out();
  end
endmodule : tb_top
`default_nettype wire
